/* File: dwbs_pkg.sv */
// Shared constants and types for the write burst sequencing link
package dwbs_pkg;
  // ----------------------------------------------------------------
  // Command link
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DWBS_DES, DWBS_MRS, DWBS_WR, DWBS_RD
  } dwbs_op_t;

  localparam int ADDR_W = 13;
  localparam int LAT_W = 5;
  localparam int DATA_W = 32;
  // Mode payload layout, shared by the mode command and the config word
  localparam int MR_BURST_LSB = 0;
  localparam int MR_PRE2_BIT = 2;
  localparam int MR_CAS_LSB = 3;
  localparam int MR_ADD_LSB = 8;
  // Burst select address bit carried by a write command
  localparam int BSEL_BIT = 12;

  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_PER_CMD = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;

  // Two beats travel per clock, so bursts last this many clocks
  localparam logic [1:0] EIGHT_BEAT_LAST = 2'h3;
  localparam logic [1:0] FOUR_CHOP_LAST = 2'h1;
  localparam logic [2:0] EIGHT_BEAT_CLK = 3'h4;
  localparam logic [2:0] FOUR_CHOP_CLK = 3'h2;

  localparam logic [LAT_W-1:0] CAS_RESET = 5'h09;
  localparam logic [ADDR_W-1:0] CFG_RESET = 13'h0048;
  localparam logic [8:0] COL_GAP_FORBID_PRE2 = 9'h005;

  // ----------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WDATA0 = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_BG_BIT = 1;
  localparam int CMD_BSEL_BIT = 2;
  localparam int ST_CMD_PEND = 0;
  localparam int ST_MRS_PEND = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_CFG_ERR = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: dwbs_link_if.sv */
// Command and write data link between controller and memory device
`timescale 1ns/100ps
interface dwbs_link_if;
  import dwbs_pkg::*;
  logic cmd_valid;
  dwbs_op_t cmd_op;
  logic cmd_bg;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] wdata;
  logic wdata_valid;

  modport ctrl (
    output cmd_valid, cmd_op, cmd_bg, cmd_addr, wdata, wdata_valid
  );
  modport dram (
    input cmd_valid, cmd_op, cmd_bg, cmd_addr, wdata, wdata_valid
  );
endinterface

/* File: dwbs_dram_end.sv */
// Memory device end: mode capture, burst length choice, write capture
`timescale 1ns/100ps
module dwbs_dram_end import dwbs_pkg::*; #(
  parameter int SCHED_DEPTH = 64
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  dwbs_link_if.dram link,
  output logic [DATA_W-1:0] wr_data_out,
  output logic wr_valid_out,
  output logic wr_bg_out,
  output logic wr_last_out,
  output logic burst_end_out,
  output logic strobe_err_out,
  output logic [1:0] burst_field_out,
  output logic [LAT_W:0] wr_lat_out
);
  initial begin
    if (SCHED_DEPTH < 64) $error("SCHED_DEPTH must cover largest latency");
  end

  typedef struct packed {
    logic vld;
    logic chop;
    logic bg;
  } dwbs_dslot_t;

  typedef struct packed {
    dwbs_dslot_t [SCHED_DEPTH-1:0] sched;
    logic [1:0] burst;
    logic pre2;
    logic [LAT_W-1:0] cas_lat;
    logic [LAT_W-1:0] add_lat;
    logic [LAT_W:0] wl;
    logic [1:0] cnt;
    logic bg;
    logic [DATA_W-1:0] data;
    logic valid;
    logic last;
    logic done;
    logic err;
  } dwbs_dram_st_t;

  dwbs_dram_st_t r, n;

  always_comb begin
    logic [5:0] idx;
    logic chop;
    logic start;
    logic [1:0] rem;
    n = r;
    n.valid = 1'b0;
    n.last = 1'b0;
    n.done = r.last;
    for (int i = 0; i < SCHED_DEPTH - 1; i++) begin
      n.sched[i] = r.sched[i+1];
    end
    n.sched[SCHED_DEPTH-1] = '0;
    idx = 6'(r.wl - 6'h01);
    chop = (r.burst == BURST_FIXED4) ||
      (r.burst == BURST_PER_CMD && !link.cmd_addr[BSEL_BIT]);
    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    if (link.cmd_valid) begin
      case (link.cmd_op)
        DWBS_MRS: begin
          n.burst = link.cmd_addr[MR_BURST_LSB +: 2];
          n.pre2 = link.cmd_addr[MR_PRE2_BIT];
          n.cas_lat = link.cmd_addr[MR_CAS_LSB +: LAT_W];
          n.add_lat = link.cmd_addr[MR_ADD_LSB +: LAT_W];
          n.wl = {1'b0, n.add_lat} + {1'b0, n.cas_lat};
        end
        DWBS_WR: begin
          // Each write keeps its own length in its slot
          n.sched[idx] = '{vld: 1'b1, chop: chop, bg: link.cmd_bg};
        end
        default: begin
        end
      endcase
    end
    // ----------------------------------------------------------------
    // Data capture
    // ----------------------------------------------------------------
    start = r.sched[0].vld;
    rem = 2'h0;
    if (start || r.cnt != 2'h0) begin
      // Eight beats unless chopped
      rem = start ? (r.sched[0].chop ? FOUR_CHOP_LAST : EIGHT_BEAT_LAST)
                  : 2'(r.cnt - 2'h1);
      n.cnt = rem;
      if (start) begin
        n.bg = r.sched[0].bg;
      end
      n.data = link.wdata;
      n.valid = link.wdata_valid;
      n.last = (rem == 2'h0);
      if (!link.wdata_valid) begin
        n.err = 1'b1;
      end
    end else if (link.wdata_valid) begin
      // Strobe outside any window is a controller fault
      n.err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.cas_lat <= CAS_RESET;
      r.wl <= {1'b0, CAS_RESET};
    end else begin
      r <= n;
    end
  end

  assign wr_data_out = r.data;
  assign wr_valid_out = r.valid;
  assign wr_bg_out = r.bg;
  assign wr_last_out = r.last;
  assign burst_end_out = r.done;
  assign strobe_err_out = r.err;
  assign burst_field_out = r.burst;
  assign wr_lat_out = r.wl;
endmodule

/* File: dwbs_ctrl_end.sv */
// Controller end: AXI4-Lite registers, command spacing, write data drive
// Function
// - Fixed field or select high: eight beats
// - Per-command field, select low: four-beat chop
// - Fixed-chop field: every write four beats
// - Two-cycle preamble needs latency above minimum
// - Two-cycle preamble forbids column gap five
// - Write to read turnaround starts after last beat
// - Same group long turnaround, other group short
// - Additive latency pulls following read earlier
`timescale 1ns/100ps
module dwbs_ctrl_end import dwbs_pkg::*; #(
  parameter int SCHED_DEPTH = 64,
  parameter int CAS_MIN = 9,
  parameter int W2R_SHORT_CYC = 3,
  parameter int W2R_LONG_CYC = 9,
  parameter int COL_GAP_MIN = 4
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  dwbs_link_if.ctrl link
);
  initial begin
    if (SCHED_DEPTH < 64) $error("SCHED_DEPTH must cover largest latency");
    if (CAS_MIN < 2) $error("CAS_MIN too small for data lead time");
    if (COL_GAP_MIN < 4) $error("COL_GAP_MIN below eight-beat length");
  end

  localparam logic [LAT_W-1:0] CAS_MIN_V = LAT_W'(CAS_MIN);
  localparam logic [8:0] W2R_S = 9'(W2R_SHORT_CYC);
  localparam logic [8:0] W2R_L = 9'(W2R_LONG_CYC);
  localparam logic [8:0] COL_GAP = 9'(COL_GAP_MIN);

  typedef struct packed {
    logic vld;
    logic chop;
  } dwbs_cslot_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic [ADDR_W-1:0] cfg;
    logic cfg_err;
    logic mrs_pend;
    logic [2:0] cmd;
    logic cmd_pend;
    logic [3:0][DATA_W-1:0] wbuf;
    logic [1:0] burst;
    logic pre2;
    logic [LAT_W-1:0] cas_lat;
    logic [LAT_W-1:0] add_lat;
    dwbs_cslot_t [SCHED_DEPTH-1:0] sched;
    logic [1:0] cnt;
    logic [1:0] beat;
    logic [7:0] since_col;
    logic [7:0] since_wr;
    logic wr_bg;
    logic wr_chop;
    logic l_valid;
    dwbs_op_t l_op;
    logic l_bg;
    logic [ADDR_W-1:0] l_addr;
    logic [DATA_W-1:0] l_wdata;
    logic l_wvalid;
  } dwbs_ctrl_st_t;

  dwbs_ctrl_st_t r, n;

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction

  always_comb begin
    logic [DATA_W-1:0] mv;
    logic [1:0] widx;
    logic busy;
    logic [8:0] gap;
    logic [8:0] wgap;
    logic [8:0] need;
    logic col_ok;
    logic chop;
    logic [LAT_W:0] wr_lat;
    logic start;
    logic [1:0] rem;
    logic mrs_set;
    n = r;
    mv = '0;
    rem = 2'h0;
    mrs_set = 1'b0;
    widx = 2'(r.awaddr[4:2] - 3'h2);
    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    if (s_axi_awvalid_in && r.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && r.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata_in;
      n.wstrb = s_axi_wstrb_in;
    end
    if (r.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.awaddr)
        REG_CFG: begin
          mv = merge({{(DATA_W-ADDR_W){1'b0}}, r.cfg}, r.wdata, r.wstrb);
          // Too short a latency for two-cycle preamble is refused
          if (mv[MR_CAS_LSB +: LAT_W] < CAS_MIN_V ||
              (mv[MR_PRE2_BIT] &&
               mv[MR_CAS_LSB +: LAT_W] <= CAS_MIN_V)) begin
            n.cfg_err = 1'b1;
            n.bresp = RESP_SLVERR;
          end else begin
            n.cfg = mv[ADDR_W-1:0];
            n.mrs_pend = 1'b1;
            mrs_set = 1'b1;
          end
        end
        REG_CMD: begin
          mv = merge({29'h0, r.cmd}, r.wdata, r.wstrb);
          if (r.cmd_pend) begin
            n.bresp = RESP_SLVERR;
          end else begin
            n.cmd = mv[2:0];
            n.cmd_pend = 1'b1;
          end
        end
        REG_STATUS: begin
          if (r.wstrb[0] && r.wdata[ST_CFG_ERR]) n.cfg_err = 1'b0;
        end
        default: begin
          if (r.awaddr >= REG_WDATA0 && r.awaddr < REG_STATUS &&
              r.awaddr[1:0] == 2'h0) begin
            n.wbuf[widx] = merge(r.wbuf[widx], r.wdata, r.wstrb);
          end else begin
            n.bresp = RESP_SLVERR;
          end
        end
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    busy = (r.cnt != 2'h0);
    for (int i = 0; i < SCHED_DEPTH; i++) begin
      busy = busy | r.sched[i].vld;
    end
    if (r.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case (s_axi_araddr_in)
        REG_CFG: n.rdata[ADDR_W-1:0] = r.cfg;
        REG_CMD: n.rdata[2:0] = r.cmd;
        REG_STATUS: begin
          n.rdata[ST_CMD_PEND] = r.cmd_pend;
          n.rdata[ST_MRS_PEND] = r.mrs_pend;
          n.rdata[ST_BUSY] = busy;
          n.rdata[ST_CFG_ERR] = r.cfg_err;
        end
        default: begin
          if (s_axi_araddr_in >= REG_WDATA0 &&
              s_axi_araddr_in < REG_STATUS &&
              s_axi_araddr_in[1:0] == 2'h0) begin
            n.rdata = r.wbuf[2'(s_axi_araddr_in[4:2] - 3'h2)];
          end else begin
            n.rresp = RESP_SLVERR;
          end
        end
      endcase
    end
    n.arready = !n.rvalid;

    // ----------------------------------------------------------------
    // Command spacing and issue
    // ----------------------------------------------------------------
    for (int i = 0; i < SCHED_DEPTH - 1; i++) begin
      n.sched[i] = r.sched[i+1];
    end
    n.sched[SCHED_DEPTH-1] = '0;
    n.since_col = r.since_col + {7'h0, r.since_col != 8'hff};
    n.since_wr = r.since_wr + {7'h0, r.since_wr != 8'hff};
    n.l_valid = 1'b0;
    n.l_op = DWBS_DES;
    // Gap in clocks from the previous command to one issued now
    gap = {1'b0, r.since_col} + 9'h001;
    wgap = {1'b0, r.since_wr} + 9'h001;
    col_ok = gap >= COL_GAP &&
      !(r.pre2 && gap == COL_GAP_FORBID_PRE2);
    // Measured from the write command the additive part cancels out,
    // which lets the read move earlier by that amount
    need = 9'(r.cas_lat) +
      9'(r.wr_chop ? FOUR_CHOP_CLK : EIGHT_BEAT_CLK) +
      ((r.cmd[CMD_BG_BIT] == r.wr_bg) ? W2R_L : W2R_S);
    wr_lat = {1'b0, r.add_lat} + {1'b0, r.cas_lat};
    chop = (r.burst == BURST_FIXED4) ||
      (r.burst == BURST_PER_CMD && !r.cmd[CMD_BSEL_BIT]);
    if (r.mrs_pend && !busy && col_ok) begin
      // Latency change only between bursts keeps slots consistent
      // A config write landing now stays queued for the next mode command
      n.mrs_pend = mrs_set;
      n.l_valid = 1'b1;
      n.l_op = DWBS_MRS;
      n.l_addr = r.cfg;
      n.burst = r.cfg[MR_BURST_LSB +: 2];
      n.pre2 = r.cfg[MR_PRE2_BIT];
      n.cas_lat = r.cfg[MR_CAS_LSB +: LAT_W];
      n.add_lat = r.cfg[MR_ADD_LSB +: LAT_W];
      n.since_col = 8'h00;
    end else if (r.cmd_pend && !r.mrs_pend && col_ok) begin
      if (r.cmd[CMD_READ_BIT]) begin
        if (wgap >= need) begin
          n.cmd_pend = 1'b0;
          n.l_valid = 1'b1;
          n.l_op = DWBS_RD;
          n.l_bg = r.cmd[CMD_BG_BIT];
          n.l_addr = '0;
          n.since_col = 8'h00;
        end
      end else begin
        n.cmd_pend = 1'b0;
        n.l_valid = 1'b1;
        n.l_op = DWBS_WR;
        n.l_bg = r.cmd[CMD_BG_BIT];
        n.l_addr = '0;
        n.l_addr[BSEL_BIT] = r.cmd[CMD_BSEL_BIT];
        // Command register and data register each add one clock, so
        // the strobe stands in the clock before the device samples it
        n.sched[6'(wr_lat - 6'h01)] = '{vld: 1'b1, chop: chop};
        n.since_col = 8'h00;
        n.since_wr = 8'h00;
        n.wr_bg = r.cmd[CMD_BG_BIT];
        n.wr_chop = chop;
      end
    end

    // ----------------------------------------------------------------
    // Write data drive
    // ----------------------------------------------------------------
    // Buffer words are read live: rewriting them mid-burst corrupts it
    start = r.sched[0].vld;
    n.l_wvalid = 1'b0;
    if (start || r.cnt != 2'h0) begin
      rem = start ? (r.sched[0].chop ? FOUR_CHOP_LAST : EIGHT_BEAT_LAST)
                  : 2'(r.cnt - 2'h1);
      n.cnt = rem;
      n.beat = start ? 2'h0 : 2'(r.beat + 2'h1);
      n.l_wvalid = 1'b1;
      n.l_wdata = r.wbuf[n.beat];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.cfg <= CFG_RESET;
      r.cas_lat <= CAS_RESET;
      r.since_col <= 8'hff;
      r.since_wr <= 8'hff;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready_out = r.awready;
  assign s_axi_wready_out = r.wready;
  assign s_axi_bresp_out = r.bresp;
  assign s_axi_bvalid_out = r.bvalid;
  assign s_axi_arready_out = r.arready;
  assign s_axi_rdata_out = r.rdata;
  assign s_axi_rresp_out = r.rresp;
  assign s_axi_rvalid_out = r.rvalid;
  assign link.cmd_valid = r.l_valid;
  assign link.cmd_op = r.l_op;
  assign link.cmd_bg = r.l_bg;
  assign link.cmd_addr = r.l_addr;
  assign link.wdata = r.l_wdata;
  assign link.wdata_valid = r.l_wvalid;
endmodule

/* File: dwbs_link_monitor.sv */
// Checker for the command and write data link between the two ends
`timescale 1ns/100ps
module dwbs_link_monitor import dwbs_pkg::*; #(
  parameter int W2R_SHORT_CYC = 3,
  parameter int W2R_LONG_CYC = 9
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic cmd_valid,
  input wire dwbs_op_t cmd_op,
  input wire logic cmd_bg,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wdata_valid
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------------------------------
  // Shadow of the mode in force and of the expected strobe window
  // ----------------------------------------------------------------
  logic [1:0] fld_r;
  logic pre2_r;
  logic [4:0] cas_r;
  logic [4:0] add_r;
  logic [71:0] exp_r;
  logic [5:0] gap_r;
  logic [5:0] age_r;
  logic bg_r;
  logic [2:0] len_r;
  wire mrs = cmd_valid && cmd_op == DWBS_MRS;
  wire wr = cmd_valid && cmd_op == DWBS_WR;
  wire rd = cmd_valid && cmd_op == DWBS_RD;
  wire chop = fld_r == BURST_FIXED4 ||
    (fld_r == BURST_PER_CMD && !cmd_addr[BSEL_BIT]);
  wire [6:0] wl = 7'(add_r) + 7'(cas_r);
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fld_r <= BURST_FIXED8;
      pre2_r <= 1'b0;
      cas_r <= CAS_RESET;
      add_r <= 5'h00;
      exp_r <= 72'h0;
      gap_r <= 6'h3f;
      age_r <= 6'h3f;
      bg_r <= 1'b0;
      len_r <= EIGHT_BEAT_CLK;
    end else begin
      // Mask placed so that its bit 0 is seen at the sampling edge
      exp_r <= (exp_r >> 1) |
        (wr ? (chop ? 72'h3 : 72'hf) << (wl - 7'h1) : 72'h0);
      gap_r <= cmd_valid ? 6'h01 : gap_r + {5'h00, gap_r != 6'h3f};
      age_r <= wr ? 6'h01 : age_r + {5'h00, age_r != 6'h3f};
      if (wr) begin
        bg_r <= cmd_bg;
        len_r <= chop ? FOUR_CHOP_CLK : EIGHT_BEAT_CLK;
      end
      if (mrs) begin
        fld_r <= cmd_addr[MR_BURST_LSB +: 2];
        pre2_r <= cmd_addr[MR_PRE2_BIT];
        cas_r <= cmd_addr[MR_CAS_LSB +: LAT_W];
        add_r <= cmd_addr[MR_ADD_LSB +: LAT_W];
      end
    end
  end
  property p_gap; cmd_valid |-> gap_r >= 6'h04; endproperty
  a_gap: assert property (p_gap)
    else $error("commands closer than four clocks");
  property p_gap5; cmd_valid && pre2_r |-> gap_r != 6'h05; endproperty
  a_gap5: assert property (p_gap5)
    else $error("gap of five in two-cycle preamble mode");
  property p_pre2_cas;
    mrs && cmd_addr[MR_PRE2_BIT] |-> cmd_addr[MR_CAS_LSB +: LAT_W] > 5'h09;
  endproperty
  a_pre2_cas: assert property (p_pre2_cas)
    else $error("latency too low for two-cycle preamble");
  property p_data; 1'b1 |-> wdata_valid == exp_r[0]; endproperty
  a_data: assert property (p_data)
    else $error("data strobe window off its latency or length");
  property p_len; $rose(wdata_valid) |=> wdata_valid; endproperty
  a_len: assert property (p_len)
    else $error("burst shorter than two clocks");
  property p_w2r_l;
    rd && cmd_bg == bg_r |-> age_r >= cas_r + len_r + W2R_LONG_CYC;
  endproperty
  a_w2r_l: assert property (p_w2r_l)
    else $error("read too soon after write in same group");
  property p_w2r_s;
    rd && cmd_bg != bg_r |-> age_r >= cas_r + len_r + W2R_SHORT_CYC;
  endproperty
  a_w2r_s: assert property (p_w2r_s)
    else $error("read too soon after write in other group");
  property p_mrs_quiet; mrs |-> exp_r == 72'h0 ##1 !wdata_valid; endproperty
  a_mrs_quiet: assert property (p_mrs_quiet)
    else $error("mode command while write data in flight");
  c_pre2_wr: cover property (wr && pre2_r);
  c_chop: cover property (wr && chop);
  c_rd: cover property (rd && age_r < 6'h30);
endmodule

/* File: tb_ddr4_write_burst_sequencing.sv */
// Testbench joining controller and device ends over the link
`timescale 1ns/100ps
module tb_ddr4_write_burst_sequencing;
  import dwbs_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  logic arv = 1'b0, rrdy = 1'b0, awr, wrdy, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wdt = 32'h0, rdt, wdo, d, got[$];
  logic [1:0] bresp, rresp, r, bfld;
  logic wvo, wlast, bend, serr, wbg, last_d = 1'b0;
  logic [5:0] wlat;
  int fail_count = 0, total_checks = 0, cyc = 0, ends = 0;
  int t_wr, t_rd, t_first, tw1, n, mn, i, k;
  dwbs_link_if lk();
  dwbs_ctrl_end dwbs_ctrl_end_i (.sys_clk_in(clk), .resetn_in(rstn),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wdt),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdt),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rrdy), .link(lk.ctrl));
  dwbs_dram_end dwbs_dram_end_i (.sys_clk_in(clk), .resetn_in(rstn),
    .link(lk.dram), .wr_data_out(wdo), .wr_valid_out(wvo),
    .wr_bg_out(wbg), .wr_last_out(wlast), .burst_end_out(bend),
    .strobe_err_out(serr), .burst_field_out(bfld), .wr_lat_out(wlat));
  dwbs_link_monitor dwbs_link_monitor_i (.sys_clk_in(clk),
    .resetn_in(rstn), .cmd_valid(lk.cmd_valid), .cmd_op(lk.cmd_op),
    .cmd_bg(lk.cmd_bg), .cmd_addr(lk.cmd_addr), .wdata(lk.wdata),
    .wdata_valid(lk.wdata_valid));
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic axi_w(input logic [7:0] a, input logic [31:0] v);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a; wdt <= v; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awr && !ad) begin ad = 1'b1; awv <= 1'b0; end
      if (wrdy && !dd) begin dd = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clk); while (!bv);
    r = bresp;
    brdy <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_r(input logic [7:0] a);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge clk);
    d = rdt;
    r = rresp;
    rrdy <= 1'b0;
    @(posedge clk);
  endtask
  // Waits until neither a command nor a mode change is queued
  task automatic idle();
    do axi_r(REG_STATUS); while (d[1:0] != 2'h0);
  endtask
  task automatic wait_end(input int m);
    for (int j = 0; j < 300 && ends < m; j++) @(posedge clk);
  endtask
  function automatic logic [31:0] word(input int a, input int b);
    return 32'h5a00_0000 | (32'(a) << 8) | 32'(b);
  endfunction
  // ----------------------------------------------------------------
  // Link observation and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (lk.cmd_valid && lk.cmd_op == DWBS_WR) begin
      tw1 = t_wr;
      t_wr = cyc;
    end
    if (lk.cmd_valid && lk.cmd_op == DWBS_RD) t_rd = cyc;
    if (wvo && got.size() == 0) t_first = cyc;
    if (wvo) got.push_back(wdo);
    if (bend) begin
      ends++;
      chk(32'(last_d), 32'h1);
    end
    last_d = wlast;
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(32'(bfld), 32'h0);
    chk(32'(wlat), 32'h9);
    axi_r(REG_CFG);
    chk(d, 32'h48);
    axi_r(8'h1c);
    chk(32'(r), 32'(RESP_SLVERR));
    // Every burst field against both select levels, rising latency
    for (i = 0; i < 6; i++) begin
      axi_w(REG_CFG, 32'(i / 2) | 32'h48 | (32'(i) << 8));
      for (k = 0; k < 4; k++) axi_w(REG_WDATA0 + 8'(4 * k), word(i, k));
      got.delete();
      n = ends;
      axi_w(REG_CMD, 32'(i % 2) << 2);
      wait_end(n + 1);
      mn = (i < 2 || i == 3) ? 4 : 2;
      chk(32'(got.size()), 32'(mn));
      for (k = 0; k < mn; k++) chk(got[k], word(i, k));
      chk(32'(t_first - t_wr), 32'(10 + i));
      chk(32'(bfld), 32'(i / 2));
      chk(32'(wlat), 32'(9 + i));
    end
    // Eight-beat then chopped burst under per-command selection
    axi_w(REG_CFG, 32'h49);
    idle();
    got.delete();
    n = ends;
    axi_w(REG_CMD, 32'h4);
    idle();
    axi_w(REG_CMD, 32'h2);
    wait_end(n + 2);
    chk(32'(got.size()), 32'h6);
    chk(32'(wbg), 32'h1);
    chk(got[4], word(5, 0));
    chk(got[5], word(5, 1));
    // Write to read turnaround per group, with and without pull-in
    for (i = 0; i < 3; i++) begin
      axi_w(REG_CFG, 32'h48 | (i > 0 ? 32'h400 : 32'h0));
      idle();
      axi_w(REG_CMD, 32'h0);
      idle();
      axi_w(REG_CMD, i == 1 ? 32'h3 : 32'h1);
      idle();
      mn = 13 + (i == 1 ? 3 : 9);
      chk(32'(t_rd - t_wr >= mn && t_rd - t_wr <= mn + 1), 32'h1);
    end
    // Two-cycle preamble: minimum latency refused, one above accepted
    axi_w(REG_CFG, 32'h4c);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_r(REG_STATUS);
    chk(32'(d[ST_CFG_ERR]), 32'h1);
    axi_r(REG_CFG);
    chk(d, 32'h448);
    axi_w(REG_STATUS, 32'h8);
    axi_r(REG_STATUS);
    chk(32'(d[ST_CFG_ERR]), 32'h0);
    axi_w(REG_CFG, 32'h54);
    chk(32'(r), 32'(RESP_OKAY));
    idle();
    got.delete();
    n = ends;
    axi_w(REG_CMD, 32'h0);
    // One spare clock puts the second command on the forbidden gap
    @(posedge clk);
    axi_w(REG_CMD, 32'h0);
    wait_end(n + 2);
    chk(32'(t_first - tw1), 32'd11);
    chk(32'(t_wr - tw1 >= 4 && t_wr - tw1 != 5), 32'h1);
    chk(32'(serr), 32'h0);
    end_of_test();
  end
endmodule
